//--- core/serial_master.sv
// serial master: frame sequencer, pin timing and assertions
`timescale 1ns/1ps
`include "sm_defs.svh"
module serial_master
  import sm_pkg::*;
#(
  parameter int max_frame_size_param = 32,
  parameter int SLAVE_COUNT = 1
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic BLOCK_ENABLE_I,
  input wire logic [SLAVE_COUNT-1:0] SLAVE_SELECT_ENABLE_I,
  input wire logic [15:0] CONTROL_REG_0_I,
  input wire logic [2:0] PROTOCOL_CONTROL_I,
  input wire logic [15:0] FRAME_COUNT_I,
  input wire logic [15:0] CLOCK_DIVIDER_I,
  input wire logic TX_VALID_I,
  input wire logic [max_frame_size_param-1:0] TX_DATA_I,
  output logic TX_POP_O,
  output logic RX_PUSH_O,
  output logic [max_frame_size_param-1:0] RX_DATA_O,
  output logic BUSY_O,
  output logic SCLK_O,
  output logic [SLAVE_COUNT-1:0] SS_N_O,
  output logic TXD_O,
  input wire logic RXD_I
);
  localparam int LW = $clog2(max_frame_size_param);

  // ==========================================================
  // configuration decode
  function automatic logic [LW-1:0] fit_len(input logic [4:0] v, input logic [4:0] lo);
    logic [4:0] t;
    t = (v < lo) ? lo : v;
    fit_len = (int'(t) > max_frame_size_param - 1) ? LW'(max_frame_size_param - 1) : LW'(t);
  endfunction

  wire three_wire = (CONTROL_REG_0_I[`CR0_FRF_LSB +: 2] == `FRF_3WIRE);
  wire [1:0] transfer_mode = CONTROL_REG_0_I[`CR0_MODE_LSB +: 2];
  wire cpol = CONTROL_REG_0_I[`CR0_POL_BIT];
  // three-wire frames always drive at bit start and sample mid-bit
  wire cpha = CONTROL_REG_0_I[`CR0_PHASE_BIT] && !three_wire;
  wire toggle = CONTROL_REG_0_I[`CR0_TOGGLE_BIT];
  wire seq_mode = PROTOCOL_CONTROL_I[`PCR_SEQ_BIT];
  wire dir_tx = PROTOCOL_CONTROL_I[`PCR_DIR_BIT];
  wire hsk_en = PROTOCOL_CONTROL_I[`PCR_HSK_BIT];
  wire [LW-1:0] dfs_m1 = fit_len(CONTROL_REG_0_I[`CR0_DFS_LSB +: 5], `DATA_MIN_M1);
  wire [LW-1:0] ctl_len_m1 = fit_len({1'b0, CONTROL_REG_0_I[`CR0_CLEN_LSB +: 4]}, `CTRL_MIN_M1);
  // select pulse between frames only for phase 0
  wire gap_mode = !three_wire && !cpha && toggle;

  // ==========================================================
  // state
  state_type state_r, state_nxt;
  frame_type frame_r, new_fr, dec_fr, pfr_r, first_fr;
  act_type take, dec_act, pend_r;
  logic half_r, half_nxt;
  logic keep_r, new_keep, dec_keep, pkeep_r, first_keep;
  logic hold_r, take_en, go_poll, tick;
  logic [16:0] rx_cnt_r;
  logic ss_act_r, sclk_r, txd_r, push_r, busy_r;
  logic [max_frame_size_param-1:0] rx_data_r;
  logic rxd_m1_r, rxd_m2_r, rxd_m3_r, rxd_s_r;
  shift_if #(.W(max_frame_size_param)) sh ();

  // ==========================================================
  // receive pin synchroniser; a change counts once stages 2 and 3 agree
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rxd_m1_r <= 1'b0;
      rxd_m2_r <= 1'b0;
      rxd_m3_r <= 1'b0;
      rxd_s_r <= 1'b0;
    end else begin
      rxd_m1_r <= RXD_I;
      rxd_m2_r <= rxd_m1_r;
      rxd_m3_r <= rxd_m2_r;
      if (rxd_m2_r == rxd_m3_r) begin
        rxd_s_r <= rxd_m3_r;
      end
    end
  end

  clk_gen clk_gen_i (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .run_i(state_r != ST_IDLE),
    .div_i(CLOCK_DIVIDER_I),
    .tick_o(tick)
  );

  shift_reg #(.W(max_frame_size_param)) shift_reg_i (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .sh(sh)
  );

  // ==========================================================
  // start conditions and first frame
  // queued word plus enabled slave
  wire start_ok = BLOCK_ENABLE_I && (|SLAVE_SELECT_ENABLE_I) && TX_VALID_I;
  wire frame_end = (state_r == ST_SHIFT) && tick && half_r && sh.last;
  wire [16:0] rx_cnt_nxt = rx_cnt_r + {16'h0000, keep_r};
  // sequential stop at frame count plus one
  wire cnt_hit = (rx_cnt_nxt == {1'b0, FRAME_COUNT_I} + 17'h00001);

  // mode 00 keeps, mode 01 discards, memory read starts uncaptured
  assign first_fr = (three_wire || transfer_mode == `MODE_MEMREAD) ? FR_CTRL : FR_DATA;
  assign first_keep = !three_wire
      && (transfer_mode == `MODE_TXRX || transfer_mode == `MODE_RXONLY);

  // ==========================================================
  // decision at the end of each frame
  always_comb begin
    dec_act = ACT_END;
    dec_fr = FR_DATA;
    dec_keep = 1'b0;
    go_poll = 1'b0;
    if (three_wire) begin
      if (frame_r == FR_CTRL) begin
        // direction only picks who sends the data frame
        dec_keep = !dir_tx;
        dec_act = dir_tx ? (TX_VALID_I ? ACT_POP : ACT_END) : ACT_RX;
      end else if (!dir_tx && seq_mode) begin
        dec_keep = 1'b1;
        dec_act = cnt_hit ? ACT_END : ACT_RX;
      end else begin
        // next control word or stop on empty queue
        dec_fr = FR_CTRL;
        dec_act = TX_VALID_I ? ACT_POP : ACT_END;
        // with handshake, poll slave after every transmitted data frame
        go_poll = dir_tx && hsk_en;
      end
    end else begin
      case (transfer_mode)
        `MODE_TXRX, `MODE_TXONLY: begin
          dec_keep = (transfer_mode == `MODE_TXRX);
          dec_act = TX_VALID_I ? ACT_POP : ACT_END;
        end
        `MODE_RXONLY: begin
          dec_keep = 1'b1;
          dec_act = cnt_hit ? ACT_END : ACT_RX;
        end
        default: begin
          // opcode and address first, then read data
          if (frame_r == FR_CTRL && TX_VALID_I) begin
            dec_fr = FR_CTRL;
            dec_act = ACT_POP;
          end else begin
            dec_keep = 1'b1;
            dec_act = cnt_hit ? ACT_END : ACT_RX;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    half_nxt = half_r;
    take = ACT_END;
    take_en = 1'b0;
    new_fr = dec_fr;
    new_keep = dec_keep;
    sh.capture = 1'b0;
    sh.advance = 1'b0;
    case (state_r)
      ST_IDLE: begin
        // start as soon as one word and a slave are present
        if (start_ok) begin
          take = ACT_POP;
          take_en = 1'b1;
          new_fr = first_fr;
          new_keep = first_keep;
        end
      end
      ST_SETUP: begin
        if (tick) begin
          state_nxt = ST_SHIFT;
          half_nxt = 1'b0;
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          if (!half_r) begin
            half_nxt = 1'b1;
            sh.capture = 1'b1;
          end else if (!sh.last) begin
            half_nxt = 1'b0;
            sh.advance = 1'b1;
          end else if (go_poll) begin
            state_nxt = ST_POLL;
          end else begin
            take = dec_act;
            take_en = 1'b1;
          end
        end
      end
      ST_GAP: begin
        if (tick) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_POLL: begin
        // nothing more is sent until the slave reads ready
        if (tick && rxd_s_r) begin
          take = pend_r;
          take_en = 1'b1;
          new_fr = pfr_r;
          new_keep = pkeep_r;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (take_en) begin
      // back to back unless a select pulse is wanted
      if (take == ACT_END) begin
        state_nxt = ST_IDLE;
      end else if (state_r == ST_IDLE) begin
        state_nxt = ST_SETUP;
      end else if (gap_mode) begin
        state_nxt = ST_GAP;
      end else begin
        state_nxt = ST_SHIFT;
        half_nxt = 1'b0;
      end
    end
    if (!BLOCK_ENABLE_I) begin
      state_nxt = ST_IDLE;
    end
  end

  // shifter loading; a receive frame shifts zeros out
  assign TX_POP_O = take_en && (take == ACT_POP) && BLOCK_ENABLE_I;
  assign sh.load = take_en && (take != ACT_END);
  assign sh.load_word = (take == ACT_POP) ? TX_DATA_I : '0;
  assign sh.bits_m1 = (three_wire && new_fr == FR_CTRL) ? ctl_len_m1 : dfs_m1;
  assign sh.in_bit = rxd_s_r;

  // ==========================================================
  // sequencer registers
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r <= ST_IDLE;
      half_r <= 1'b0;
      frame_r <= FR_CTRL;
      keep_r <= 1'b0;
      pend_r <= ACT_END;
      pfr_r <= FR_CTRL;
      pkeep_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      half_r <= half_nxt;
      if (sh.load) begin
        frame_r <= new_fr;
        keep_r <= new_keep;
      end
      if (state_r == ST_SHIFT && state_nxt == ST_POLL) begin
        pend_r <= dec_act;
        pfr_r <= dec_fr;
        pkeep_r <= dec_keep;
      end
    end
  end

  // receive count, dummy hold and received data
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_cnt_r <= 17'h00000;
      hold_r <= 1'b0;
      push_r <= 1'b0;
      rx_data_r <= '0;
    end else begin
      push_r <= frame_end && keep_r;
      if (state_r == ST_IDLE) begin
        rx_cnt_r <= 17'h00000;
        // transmit line held low through a receive-only transfer
        hold_r <= !three_wire && (transfer_mode == `MODE_RXONLY);
      end else if (frame_end) begin
        rx_cnt_r <= rx_cnt_nxt;
      end
      if (frame_end && keep_r) begin
        rx_data_r <= sh.rx_word;
      end
    end
  end

  // ==========================================================
  // pin timing: drive at bit start, sample mid-bit
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ss_act_r <= 1'b0;
      sclk_r <= 1'b0;
      txd_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      ss_act_r <= (state_nxt != ST_IDLE) && (state_nxt != ST_GAP);
      // idle level from polarity, phase sets which half is active
      sclk_r <= cpol ^ ((state_nxt == ST_SHIFT) && (cpha ? !half_nxt : half_nxt));
      txd_r <= hold_r ? 1'b0 : sh.out_bit;
      // busy from first frame until the end condition
      busy_r <= (state_nxt != ST_IDLE);
    end
  end

  assign SCLK_O = sclk_r;
  assign TXD_O = txd_r;
  assign SS_N_O = ~({SLAVE_COUNT{ss_act_r}} & SLAVE_SELECT_ENABLE_I);
  assign RX_PUSH_O = push_r;
  assign RX_DATA_O = rx_data_r;
  assign BUSY_O = busy_r;

  // ==========================================================
  // assertions
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence seq_wait_ready;
    (state_r == ST_POLL) && !rxd_s_r && BLOCK_ENABLE_I;
  endsequence
  sequence seq_next_frame_b2b;
    frame_end && cpha && (dec_act != ACT_END) && !go_poll && BLOCK_ENABLE_I;
  endsequence

  AST_START_NEEDS_SLAVE: assert property ($rose(BUSY_O) |-> $past(start_ok))
    else $error("transfer started without a slave or queued word");
  AST_START_PROMPT: assert property ((state_r == ST_IDLE && start_ok) |=> BUSY_O)
    else $error("transfer did not start on a ready queue");
  AST_DIR_TX_END: assert property ((frame_end && three_wire && dir_tx && !hsk_en
      && frame_r == FR_DATA && !TX_VALID_I) |=> !BUSY_O ##1 (!BUSY_O || $past(start_ok)))
    else $error("transmit direction did not end on empty queue");
  AST_SEQ_COUNT: assert property ((frame_end && three_wire && !dir_tx && seq_mode
      && keep_r && cnt_hit) |=> !BUSY_O)
    else $error("sequential receive missed its frame count");
  AST_HSK_HOLD: assert property (seq_wait_ready |-> !TX_POP_O ##1 BUSY_O)
    else $error("handshake wait released without ready");
  AST_HSK_NO_FRAME: assert property (seq_wait_ready |=> (state_r == ST_POLL) [*1])
    else $error("next frame sent before slave ready");
  AST_IDLE_POLARITY: assert property ((state_r == ST_IDLE && state_nxt == ST_IDLE)
      |=> SCLK_O == $past(cpol))
    else $error("serial clock not at its idle level");
  AST_TOGGLE_GAP: assert property ((state_nxt == ST_GAP && BLOCK_ENABLE_I)
      |=> (&SS_N_O) && SCLK_O == $past(cpol))
    else $error("select not released or clock active between frames");
  AST_PHASE1_B2B: assert property (seq_next_frame_b2b |=> state_r == ST_SHIFT ##1 ss_act_r)
    else $error("phase 1 frames not back to back");
  AST_TXONLY_DISCARD: assert property ((state_r != ST_IDLE && !three_wire
      && transfer_mode == `MODE_TXONLY) |=> !RX_PUSH_O)
    else $error("transmit-only mode pushed received data");
  AST_RXONLY_HOLD: assert property ((hold_r && BUSY_O) |=> !TXD_O)
    else $error("transmit line moved in receive-only mode");
endmodule

//--- core/sm_defs.svh
// field positions and codes of the serial master control ports
// Function
// - three-wire transfer starts only with a queued control word and an enabled slave
// - control frame always goes from master; direction picks who sends data
// - master-transmit three-wire transfer ends when transmit queue is empty
// - nonsequential receive ends on empty transmit queue after the data frame
// - sequential receive ends when received frames equal frame count plus one
// - with handshake, busy clears only after slave reports ready
// - with handshake, next control frame waits for slave ready
// - transfer starts on one queued word once a slave is enabled
// - busy returns to zero when the transfer completes
// - clock polarity selects serial clock idle level
// - both ends use the same clock phase and polarity
// - data frame length programmable from 4 bits to the maximum size
// - phase 0: first bit driven before the first clock edge
// - phase 0 with toggle: select pulses high between frames, clock idle
// - phase 1: data driven on leading edge, captured on trailing edge
// - phase 1: frames back to back with select held active
// - mode field bits 9:8; code 00 transmits and keeps all received frames
// - mode 01 transmits and discards received bits
// - mode 10 pops one dummy word, holds transmit line constant, receives
// - mode 11 sends opcode and address uncaptured, then keeps read data
// - protocol control bit 0 sequential, bit 1 direction, bit 2 handshake
`ifndef SM_DEFS_SVH
`define SM_DEFS_SVH
`define CR0_DFS_LSB 0
`define CR0_FRF_LSB 5
`define CR0_PHASE_BIT 7
`define CR0_MODE_LSB 8
`define CR0_POL_BIT 10
`define CR0_TOGGLE_BIT 11
`define CR0_CLEN_LSB 12
`define PCR_SEQ_BIT 0
`define PCR_DIR_BIT 1
`define PCR_HSK_BIT 2
`define FRF_3WIRE 2'h2
`define MODE_TXRX 2'h0
`define MODE_TXONLY 2'h1
`define MODE_RXONLY 2'h2
`define MODE_MEMREAD 2'h3
`define DATA_MIN_M1 5'h03
`define CTRL_MIN_M1 5'h00
`endif

//--- core/sm_pkg.sv
// types shared by the serial master modules
package sm_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_SHIFT, ST_GAP, ST_POLL} state_type;
  typedef enum logic {FR_CTRL, FR_DATA} frame_type;
  typedef enum logic [1:0] {ACT_END, ACT_POP, ACT_RX} act_type;
endpackage

//--- core/shift_if.sv
// link between the frame sequencer and the shift register
`timescale 1ns/1ps
interface shift_if #(parameter int W = 32);
  logic load;
  logic [W-1:0] load_word;
  logic [$clog2(W)-1:0] bits_m1;
  logic advance;
  logic capture;
  logic in_bit;
  logic out_bit;
  logic last;
  logic [W-1:0] rx_word;
  modport engine (output load, load_word, bits_m1, advance, capture, in_bit,
                  input out_bit, last, rx_word);
  modport shifter (input load, load_word, bits_m1, advance, capture, in_bit,
                   output out_bit, last, rx_word);
endinterface

//--- core/clk_gen.sv
// half-period tick generator for the serial clock
`timescale 1ns/1ps
module clk_gen (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic [15:0] div_i,
  output logic tick_o
);
  logic [14:0] cnt_r;
  wire [14:0] half;

  // odd divider rounds down; zero or one still gives a one-cycle half
  assign half = (div_i[15:1] == 15'h0000) ? 15'h0001 : div_i[15:1];
  assign tick_o = run_i && (cnt_r == half - 15'h0001);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 15'h0000;
    end else if (!run_i || tick_o) begin
      cnt_r <= 15'h0000;
    end else begin
      cnt_r <= cnt_r + 15'h0001;
    end
  end
endmodule

//--- core/shift_reg.sv
// msb-first shift register with separate transmit and receive halves
`timescale 1ns/1ps
module shift_reg #(parameter int W = 32) (
  input wire logic clk_i,
  input wire logic resetn_i,
  shift_if.shifter sh
);
  logic [W-1:0] tx_r;
  logic [W-1:0] rx_r;
  localparam int CW = $clog2(W);
  logic [CW-1:0] cnt_r;

  // word is left-justified so the frame msb leaves first
  assign sh.out_bit = tx_r[W-1];
  assign sh.last = (cnt_r == '0);
  assign sh.rx_word = rx_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_r <= '0;
      rx_r <= '0;
      cnt_r <= '0;
    end else if (sh.load) begin
      tx_r <= sh.load_word << (W - 1 - int'(sh.bits_m1));
      rx_r <= '0;
      cnt_r <= sh.bits_m1;
    end else begin
      if (sh.advance) begin
        tx_r <= {tx_r[W-2:0], 1'b0};
        cnt_r <= cnt_r - CW'(1);
      end
      if (sh.capture) begin
        rx_r <= {rx_r[W-2:0], sh.in_bit};
      end
    end
  end
endmodule

//--- testbench/slave_model.sv
// behavioural serial slave facing the serial master
`timescale 1ns/1ps
module slave_model #(parameter int W = 8) (
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic txd_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic hold_i,
  input wire logic ready_i,
  input wire logic [W-1:0] base_i,
  output logic rxd_o,
  output logic [W-1:0] got_o,
  output int n_got_o
);
  logic [W-1:0] sh;
  logic [W-1:0] cap;
  logic d = 1'b0;
  logic ss_d = 1'b1;
  int nb = 0;
  initial n_got_o = 0;
  // ==========================================
  // frame bookkeeping
  // each reply is the base plus the frame index, so the bench can predict it
  task automatic done();
    got_o = cap;
    n_got_o++;
    nb = 0;
    sh = base_i + W'(n_got_o);
  endtask
  // handshake status overrides the line only while the bench asks for it
  assign rxd_o = hold_i ? ready_i : d;
  // select seen 1 ns late, so a last clock edge that meets the release still counts
  always @(ss_n_i) ss_d <= #1 ss_n_i;
  always @(negedge ss_n_i) begin
    nb = 0;
    sh = base_i + W'(n_got_o);
    if (!cpha_i) d = sh[W-1];
  end
  // deselected line must not keep a stale value
  always @(posedge ss_n_i) begin
    #2;
    d = ~d;
  end
  always @(sclk_i) begin
    if (ss_d === 1'b0) begin
      if ((sclk_i ^ cpol_i ^ cpha_i) == 1'b1) begin
        cap = {cap[W-2:0], txd_i};
        nb++;
        if (cpha_i && nb == W) done();
      end else if (!cpha_i) begin
        if (nb == W) done();
        else sh = sh << 1;
        d = sh[W-1];
      end else begin
        d = sh[W-1];
        sh = sh << 1;
      end
    end
  end
endmodule

//--- testbench/test_serial_master_frame_control.sv
// self-checking bench for the serial master
`timescale 1ns/1ps
module test_serial_master_frame_control;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic en = 1'b0;
  logic sse = 1'b0;
  logic txv = 1'b0;
  logic hold = 1'b0;
  logic rdy = 1'b0;
  logic popped = 1'b0;
  logic pop, push, busy, sclk, ss_n, txd, rxd;
  logic [15:0] cr0 = 16'h0000;
  logic [15:0] fc = 16'h0000;
  logic [15:0] div = 16'h0014;
  logic [2:0] pcr = 3'h0;
  logic [31:0] txw = 32'h0000_0000;
  logic [31:0] rxw;
  logic [7:0] got;
  logic [31:0] txq[$];
  logic [31:0] rxq[$];
  int n_got;
  int n_ss = 0;
  int n_errors = 0;
  int n_tests = 0;
  // ==========================================
  // clock, design and partner
  initial begin
    forever #4 clk = ~clk;
  end
  serial_master #(.max_frame_size_param(32), .SLAVE_COUNT(1)) serial_master_i (
    .CLK_I(clk), .RESETN_I(resetn), .BLOCK_ENABLE_I(en), .SLAVE_SELECT_ENABLE_I(sse),
    .CONTROL_REG_0_I(cr0), .PROTOCOL_CONTROL_I(pcr), .FRAME_COUNT_I(fc),
    .CLOCK_DIVIDER_I(div), .TX_VALID_I(txv), .TX_DATA_I(txw), .TX_POP_O(pop),
    .RX_PUSH_O(push), .RX_DATA_O(rxw), .BUSY_O(busy), .SCLK_O(sclk), .SS_N_O(ss_n),
    .TXD_O(txd), .RXD_I(rxd));
  slave_model #(.W(8)) slave_model_i (.sclk_i(sclk), .ss_n_i(ss_n), .txd_i(txd),
    .cpol_i(cr0[10]), .cpha_i(cr0[7]), .hold_i(hold), .ready_i(rdy), .base_i(8'h50),
    .rxd_o(rxd), .got_o(got), .n_got_o(n_got));
  // ==========================================
  // queues: pops are applied at the falling edge after the popping edge
  always @(posedge clk) begin
    popped <= pop;
    if (push === 1'b1) rxq.push_back(rxw);
  end
  always @(posedge ss_n) n_ss++;
  always @(negedge clk) begin
    if (popped === 1'b1 && txq.size() > 0) void'(txq.pop_front());
    txv <= (txq.size() > 0);
    txw <= (txq.size() > 0) ? txq[0] : 32'h0000_0000;
  end
  // ==========================================
  // access tasks
  task automatic check(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [15:0] mk(input logic [1:0] m, input logic ph, pl, tg,
                                     input logic [1:0] ff, input logic [3:0] cf);
    return {cf, tg, pl, m, ph, ff, 5'h07};
  endfunction
  task automatic cfg(input logic [15:0] c, input logic [2:0] p, input logic [15:0] f);
    @(negedge clk);
    en = 1'b0;
    @(negedge clk);
    cr0 = c;
    pcr = p;
    fc = f;
    @(negedge clk);
    en = 1'b1;
  endtask
  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 3000 && busy !== v; i++) @(negedge clk);
    check(busy === v, "busy did not change in time");
  endtask
  // one transfer: load words, optionally enable the slave late, compare results
  task automatic xfer(input int nw, nrx, off, ng, eg, input bit late);
    int g0, k;
    g0 = n_got;
    rxq.delete();
    sse = !late;
    for (k = 0; k < nw; k++) txq.push_back(32'hA0 + 32'(k));
    if (late) begin
      repeat (100) @(negedge clk);
      check(busy === 1'b0 && txq.size() == nw, "started without a slave");
      sse = 1'b1;
    end
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (8) @(negedge clk);
    check(rxq.size() == nrx, "receive count");
    for (k = 0; k < nrx && k < rxq.size(); k++)
      check(rxq[k] === 32'h50 + 32'(g0 + off + k), "receive word");
    check(n_got - g0 == ng, "slave frame count");
    if (eg >= 0) check(got === 8'(eg), "slave captured word");
    check(sclk === cr0[10], "clock idle level");
    // drain the receive queue, then disable the block
    while (rxq.size() > 0) void'(rxq.pop_front());
    en = 1'b0;
  endtask
  // ==========================================
  // main sequence
  initial begin
    int k, j;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    for (k = 0; k < 4; k++) begin
      cfg(mk(2'h0, k[0], k[1], 1'b0, 2'h0, 4'h0), 3'h0, 16'h0000);
      j = n_ss;
      xfer(2, 2, 0, 2, 8'hA1, k == 0);
      check(n_ss - j == 1, "select held across frames");
    end
    cfg(mk(2'h0, 1'b0, 1'b0, 1'b1, 2'h0, 4'h0), 3'h0, 16'h0000);
    j = n_ss;
    xfer(3, 3, 0, 3, 8'hA2, 1'b0);
    check(n_ss - j == 3, "select pulses between frames");
    cfg(mk(2'h1, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0), 3'h0, 16'h0000);
    xfer(2, 0, 0, 2, 8'hA1, 1'b0);
    cfg(mk(2'h2, 1'b1, 1'b0, 1'b0, 2'h0, 4'h0), 3'h0, 16'h0002);
    xfer(1, 3, 0, 3, -1, 1'b0);
    check(got === 8'h00 || got === 8'hFF, "transmit line not constant");
    cfg(mk(2'h3, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0), 3'h0, 16'h0001);
    xfer(2, 2, 2, 4, -1, 1'b0);
    // three-wire: nonsequential, sequential and master-transmit
    cfg(mk(2'h0, 1'b0, 1'b0, 1'b0, 2'h2, 4'h7), 3'h0, 16'h0000);
    xfer(1, 1, 1, 2, -1, 1'b0);
    cfg(mk(2'h0, 1'b0, 1'b0, 1'b0, 2'h2, 4'h7), 3'h1, 16'h0001);
    xfer(1, 2, 1, 3, -1, 1'b0);
    cfg(mk(2'h0, 1'b0, 1'b0, 1'b0, 2'h2, 4'h7), 3'h2, 16'h0000);
    xfer(2, 0, 0, 2, 8'hA1, 1'b0);
    hold = 1'b1;
    cfg(mk(2'h0, 1'b0, 1'b0, 1'b0, 2'h2, 4'h7), 3'h6, 16'h0000);
    for (k = 0; k < 4; k++) txq.push_back(32'hA0 + 32'(k));
    wait_busy(1'b1);
    repeat (800) @(negedge clk);
    check(busy === 1'b1 && txq.size() == 2, "handshake did not hold");
    rdy = 1'b1;
    wait_busy(1'b0);
    check(got === 8'hA3, "handshake data word");
    hold = 1'b0;
    report_and_stop();
  end
  // watchdog: the whole sequence needs well under 40000 cycles
  initial begin
    #320000;
    n_errors++;
    report_and_stop();
  end
endmodule
